// [rtl/bfi_pkg.sv]
/*
 * Shared constants for the breaker failure initiation block: register map,
 * control and status fields, reset values, timer modes and timing counts.
 * Assumes a single 25 MHz system clock and a 32-bit classic Wishbone bus.
 */
package bfi_pkg;
	localparam int CLK_HZ        = 25000000;
	localparam int TICK_MS       = 1;
	localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int LIMIT_W       = 16;
	localparam int ADR_W         = 8;
	localparam int NUM_TMR       = 5;
	localparam int TMR_SP_A      = 0;
	localparam int TMR_SP_C      = 2;
	localparam int TMR_THREE     = 3;
	localparam int TMR_COMMON    = 4;
	localparam int NUM_PIN       = 16;

	localparam logic [ADR_W-1:0] ADR_CTRL   = 8'h00;
	localparam logic [ADR_W-1:0] ADR_T1_1P  = 8'h04;
	localparam logic [ADR_W-1:0] ADR_T1_3P  = 8'h08;
	localparam logic [ADR_W-1:0] ADR_T2     = 8'h0c;
	localparam logic [ADR_W-1:0] ADR_STATUS = 8'h10;

	localparam int CTRL_CHK      = 0;
	localparam int CTRL_REL_ASG  = 1;
	localparam int CTRL_INT_BLK  = 2;
	localparam int CTRL_INT_SNI  = 3;
	localparam int CTRL_PER_POLE = 4;
	localparam int CTRL_MODE_LO  = 5;
	localparam int CTRL_W        = 7;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h11;

	localparam logic [LIMIT_W-1:0] T1_1P_RESET = 16'h0064;
	localparam logic [LIMIT_W-1:0] T1_3P_RESET = 16'h0064;
	localparam logic [LIMIT_W-1:0] T2_RESET    = 16'h00c8;

	localparam int ST_THREE  = 3;
	localparam int ST_FLOW   = 4;
	localparam int ST_RETRIP = 5;
	localparam int ST_BACKUP = 6;
	localparam int ST_BLOCK  = 7;

	localparam int MIN_THRESHOLDS = 2;

	typedef enum logic [1:0] {
		BFI_MODE_COMMON = 2'b00,
		BFI_MODE_SPLIT  = 2'b01,
		BFI_MODE_TWO    = 2'b10
	} bfi_mode_t;
endpackage : bfi_pkg

// [rtl/bfi_timer_if.sv]
/*
 * Carrier between the initiation logic and one delay timer.
 * Assumes the controlling side drives run and limit on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface bfi_timer_if;
	logic                        run;
	logic [bfi_pkg::LIMIT_W-1:0] limit;
	logic                        expired;
	modport ctl (output run, output limit, input expired);
	modport tmr (input run, input limit, output expired);
endinterface : bfi_timer_if
`default_nettype wire

// [rtl/bfi_sync.sv]
/*
 * Two flip-flop synchroniser bank for pin inputs.
 * Assumes the inputs are asynchronous levels; the first stage feeds only the second.
 */
`timescale 1ns/1ps
`default_nettype none
module bfi_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule : bfi_sync
`default_nettype wire

// [rtl/bfi_timer.sv]
/*
 * One delay timer counting millisecond ticks while its run level is high.
 * Assumes tick is a one-cycle pulse from the system clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module bfi_timer (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic tick,
	bfi_timer_if.tmr  tif
);
	logic [bfi_pkg::LIMIT_W-1:0] cnt;

	// A dropped run clears the count so a later initiation starts from zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
		end else if (!tif.run) begin
			cnt <= '0;
		end else if (tick && cnt != tif.limit) begin
			cnt <= cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tif.expired <= 1'b0;
		end else begin
			tif.expired <= tif.run && (cnt == tif.limit);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_last_tick;
		tif.run && tick && (cnt + 16'h0001 == tif.limit) ##1 tif.run;
	endsequence

	chk_timer_clear: assert property (!tif.run |=> cnt == '0 && !tif.expired)
		else $error("timer not cleared after run dropped");
	chk_timer_expire: assert property (s_last_tick |=> tif.expired)
		else $error("timer did not expire at its limit");
endmodule : bfi_timer
`default_nettype wire

// [rtl/bfi_top.sv]
/*
 * Breaker failure initiation: combines trip starts, current criteria and
 * breaker auxiliary contacts, starts delay timers and issues the trip outputs.
 * Assumes pin inputs are asynchronous levels and a classic Wishbone master.
 */
// Design decisions made here: the register offsets and register access over Wishbone.
// How it works
// - Contacts count only while that phase's current criterion has not picked up.
// - After current picked up during a trip, vanished current means breaker open.
// - Contact check off: trip starts need current flow, contacts ignored.
// - Start-without-current input initiates even with no current flow.
// - Release not assigned: initiate from trip alone, single channel.
// - Common initiation: trip plus a current criterion starts the timers.
// - No per-pole contacts: use series of three normally open contacts.
// - Three-pole trip done when no current or all normally closed contacts closed.
// - Start-without-current initiation is judged by contact position only.
// - External block input and internal block bit inhibit all initiation.
// - Segregated mode evaluates current and initiation per phase.
// - Single-pole interruption watches current only on the tripped pole.
// - Single-phase start needs that phase alone and its current.
// - Without current a single-phase start uses that pole's contact if enabled.
// - Without per-pole contacts a single-pole trip ends when the open series opens.
// - Trips on more than one pole raise the three-phase start only.
// - Start-without-current always acts as a three-phase start.
// - An assigned release input gates every start condition.
// - Fulfilled initiation starts the associated delay timers.
// - Separate timers for common and segregated starts plus a second stage.
// - The back-up trip is a single three-pole command.
// - Common timer alone, or separate single-pole and three-pole timers.
// - A timer reaching its limit with initiation held issues the trip.
// - Current flow needs at least two of five thresholds exceeded.
`timescale 1ns/1ps
`default_nettype none
module bfi_top #(
	parameter int TICK_CYCLES = bfi_pkg::TICK_CYCLES
) (
	input  wire logic                       sys_clk,
	input  wire logic                       resetn,
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [bfi_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	input  wire logic                       phase_a_start_input,
	input  wire logic                       phase_b_start_input,
	input  wire logic                       phase_c_start_input,
	input  wire logic                       three_pole_start_input,
	input  wire logic                       start_no_current_input,
	input  wire logic                       release_input,
	input  wire logic                       block_input,
	input  wire logic [2:0]                 phase_current_above,
	input  wire logic                       residual_current_above,
	input  wire logic                       negseq_current_above,
	input  wire logic [2:0]                 aux_nc_closed,
	input  wire logic                       aux_no_series_closed,
	output logic [2:0]                      single_phase_start,
	output logic                            three_phase_start,
	output logic                            retrip,
	output logic                            backup_trip
);
	logic                        rst_n;
	logic                        rst_s1;
	logic [bfi_pkg::NUM_PIN-1:0] pins;
	logic [2:0]                  start;
	logic                        tp_in;
	logic                        sn_in;
	logic                        rel_in;
	logic                        blk_in;
	logic [2:0]                  cur_ph;
	logic [2:0]                  nc_cl;
	logic                        no_cl;
	logic [bfi_pkg::CTRL_W-1:0]  ctrl;
	logic [bfi_pkg::LIMIT_W-1:0] t1_1p;
	logic [bfi_pkg::LIMIT_W-1:0] t1_3p;
	logic [bfi_pkg::LIMIT_W-1:0] t2;
	logic [15:0]                 pre_cnt;
	logic                        tick;
	logic [2:0]                  cur_seen;
	logic                        cur3_seen;
	bfi_pkg::bfi_mode_t          mode;
	logic                        chk_en;
	logic                        blocked;
	logic                        release_ok;
	logic                        flow;
	logic [2:0]                  phase_cur;
	logic                        multi;
	logic                        three_trip;
	logic [2:0]                  alone;
	logic [2:0]                  pole_closed;
	logic                        brk_closed3;
	logic                        any_cur;
	logic                        sn_any;
	logic [2:0]                  init1;
	logic                        init3;
	logic                        t1_exp;
	logic                        t2_exp;
	logic                        bus_req;

	function automatic logic [2:0] count_set(input logic [4:0] v);
		count_set = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]);
	endfunction : count_set

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] sel);
		merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// Reset is asserted at once and released only through two flip-flops.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	bfi_sync #(
		.WIDTH (bfi_pkg::NUM_PIN)
	) u_sync (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.din   ({phase_c_start_input, phase_b_start_input, phase_a_start_input,
			three_pole_start_input, start_no_current_input, release_input,
			block_input, phase_current_above, residual_current_above,
			negseq_current_above, aux_nc_closed, aux_no_series_closed}),
		.dout  (pins)
	);

	assign {start, tp_in, sn_in, rel_in, blk_in} = pins[15:9];
	assign cur_ph = pins[8:6];
	assign nc_cl  = pins[3:1];
	assign no_cl  = pins[0];
	assign mode   = bfi_pkg::bfi_mode_t'(ctrl[bfi_pkg::CTRL_MODE_LO +: 2]);
	assign chk_en = ctrl[bfi_pkg::CTRL_CHK];

	// Two thresholds out of five guard against a single faulty detector.
	assign flow      = count_set(pins[8:4]) >= 3'(bfi_pkg::MIN_THRESHOLDS);
	assign phase_cur = cur_ph & {3{flow}};
	assign any_cur   = |phase_cur;
	assign blocked   = blk_in || ctrl[bfi_pkg::CTRL_INT_BLK];
	assign release_ok = !ctrl[bfi_pkg::CTRL_REL_ASG] || rel_in;
	assign multi     = count_set({2'b00, start}) >= 3'h2;
	assign three_trip = tp_in || multi;
	assign alone     = start & {3{!three_trip}};
	assign sn_any    = sn_in || ctrl[bfi_pkg::CTRL_INT_SNI];

	// Without per-pole contacts every pole follows the open-contact series chain.
	assign pole_closed = ctrl[bfi_pkg::CTRL_PER_POLE] ? ~nc_cl : {3{no_cl}};
	assign brk_closed3 = ctrl[bfi_pkg::CTRL_PER_POLE] ? !(&nc_cl) : no_cl;

	// Current seen during a trip locks the contact criterion out for that trip.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_seen  <= 3'h0;
			cur3_seen <= 1'b0;
		end else begin
			cur_seen  <= alone & (cur_seen | phase_cur);
			cur3_seen <= three_trip && (cur3_seen || any_cur);
		end
	end

	always_comb begin
		for (int p = 0; p < 3; p++) begin
			init1[p] = alone[p] && release_ok && !blocked && (phase_cur[p]
				|| (chk_en && !cur_seen[p] && pole_closed[p]));
		end
		init3 = release_ok && !blocked && (sn_any && brk_closed3
			|| three_trip && (any_cur || (chk_en && !cur3_seen && brk_closed3)));
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt <= 16'h0000;
			tick    <= 1'b0;
		end else if (pre_cnt == 16'(TICK_CYCLES - 1)) begin
			pre_cnt <= 16'h0000;
			tick    <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
			tick    <= 1'b0;
		end
	end

	bfi_timer_if tif [bfi_pkg::NUM_TMR] ();

	for (genvar i = bfi_pkg::TMR_SP_A; i <= bfi_pkg::TMR_SP_C; i++) begin : g_sp
		assign tif[i].run   = init1[i];
		assign tif[i].limit = t1_1p;
	end
	assign tif[bfi_pkg::TMR_THREE].run    = init3;
	assign tif[bfi_pkg::TMR_THREE].limit  = t1_3p;
	assign tif[bfi_pkg::TMR_COMMON].run   = init3 || (|init1);
	assign tif[bfi_pkg::TMR_COMMON].limit = t2;

	for (genvar i = 0; i < bfi_pkg::NUM_TMR; i++) begin : g_tmr
		bfi_timer u_tmr (
			.clk   (sys_clk),
			.rst_n (rst_n),
			.tick  (tick),
			.tif   (tif[i])
		);
	end

	assign t1_exp = tif[0].expired || tif[1].expired || tif[2].expired
		|| tif[bfi_pkg::TMR_THREE].expired;
	assign t2_exp = tif[bfi_pkg::TMR_COMMON].expired;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			single_phase_start <= 3'h0;
			three_phase_start  <= 1'b0;
		end else begin
			single_phase_start <= init1;
			three_phase_start  <= init3;
		end
	end

	// The back-up trip always goes to all adjacent breakers on three poles.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			retrip      <= 1'b0;
			backup_trip <= 1'b0;
		end else begin
			case (mode)
				bfi_pkg::BFI_MODE_COMMON: begin
					retrip      <= 1'b0;
					backup_trip <= t2_exp;
				end
				bfi_pkg::BFI_MODE_SPLIT: begin
					retrip      <= 1'b0;
					backup_trip <= t1_exp;
				end
				bfi_pkg::BFI_MODE_TWO: begin
					retrip      <= t1_exp;
					backup_trip <= t2_exp;
				end
				default: begin
					retrip      <= 1'b0;
					backup_trip <= 1'b0;
				end
			endcase
		end
	end

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl  <= bfi_pkg::CTRL_RESET;
			t1_1p <= bfi_pkg::T1_1P_RESET;
			t1_3p <= bfi_pkg::T1_3P_RESET;
			t2    <= bfi_pkg::T2_RESET;
		end else if (bus_req && wb_we_i) begin
			case (wb_adr_i)
				bfi_pkg::ADR_CTRL: begin
					if (wb_sel_i[0]) begin
						ctrl <= wb_dat_i[bfi_pkg::CTRL_W-1:0];
					end
				end
				bfi_pkg::ADR_T1_1P: t1_1p <= merge16(t1_1p, wb_dat_i, wb_sel_i);
				bfi_pkg::ADR_T1_3P: t1_3p <= merge16(t1_3p, wb_dat_i, wb_sel_i);
				bfi_pkg::ADR_T2:    t2 <= merge16(t2, wb_dat_i, wb_sel_i);
				default: begin
				end
			endcase
		end
	end

	// Unmapped addresses still acknowledge, reading zero, so a stray access never hangs.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					bfi_pkg::ADR_CTRL:   wb_dat_o <= 32'(ctrl);
					bfi_pkg::ADR_T1_1P:  wb_dat_o <= 32'(t1_1p);
					bfi_pkg::ADR_T1_3P:  wb_dat_o <= 32'(t1_3p);
					bfi_pkg::ADR_T2:     wb_dat_o <= 32'(t2);
					bfi_pkg::ADR_STATUS: wb_dat_o <= 32'({blocked, backup_trip, retrip,
						flow, three_phase_start, single_phase_start});
					default:             wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_no_init;
		!(init3 || (|init1)) [*2];
	endsequence

	chk_block_inhibit: assert property (blocked |=> !three_phase_start && single_phase_start == 3'h0)
		else $error("start raised while blocked");
	chk_release_gate: assert property (ctrl[bfi_pkg::CTRL_REL_ASG] && !rel_in
		|=> !three_phase_start && single_phase_start == 3'h0)
		else $error("start raised without release");
	chk_multi_pole: assert property (multi && release_ok && !blocked && any_cur
		|=> three_phase_start && single_phase_start == 3'h0)
		else $error("multi-pole trip not three-phase");
	chk_single_alone: assert property (single_phase_start[0]
		|-> $past(start[0] && !start[1] && !start[2] && !tp_in))
		else $error("single start without lone trip");
	chk_no_contact_off: assert property (!chk_en && !sn_any && !any_cur
		|=> !three_phase_start && single_phase_start == 3'h0)
		else $error("contacts used with check disabled");
	chk_flow_two: assert property (count_set(pins[8:4]) < 3'h2 && !chk_en && !sn_any
		|=> !three_phase_start && single_phase_start == 3'h0)
		else $error("start on fewer than two thresholds");
	chk_sn_start: assert property (sn_in && release_ok && !blocked && brk_closed3
		|=> three_phase_start)
		else $error("start without current ignored");
	chk_trip_clear: assert property (s_no_init |=> !backup_trip && !retrip)
		else $error("trip held after initiation dropped");
	chk_lockout: assert property (cur_seen[0] && alone[0] && !phase_cur[0] |-> !init1[0])
		else $error("contact used after current pickup");
endmodule : bfi_top
`default_nettype wire

// [tb/bfi_feeder_model.sv]
/*
 * Feeder protection and circuit breaker model: repeats trip commands on the
 * start pins and lets fault current flow through every closed tripped pole.
 * Assumes the bench drives its controls just after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module bfi_feeder_model (
	input  wire logic        sys_clk,
	input  wire logic [2:0]  trip,
	input  wire logic        stuck,
	input  wire logic [15:0] open_delay,
	output logic      [2:0]  start_pins,
	output logic      [2:0]  cur,
	output logic             resid,
	output logic      [2:0]  nc_closed,
	output logic             no_series
);
	logic [2:0]  pole_closed;
	logic [15:0] cnt [3];

	// A stuck breaker never opens, so fault current keeps flowing.
	// Poles close again as soon as the trip drops, standing in for a fast reclose.
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (!trip[i]) begin
				cnt[i]         <= 16'h0000;
				pole_closed[i] <= 1'b1;
			end else if (cnt[i] >= open_delay && !stuck) begin
				pole_closed[i] <= 1'b0;
			end else begin
				cnt[i] <= cnt[i] + 16'h0001;
			end
		end
	end

	assign start_pins = trip;
	assign cur        = trip & pole_closed;
	assign resid      = |cur;
	assign nc_closed  = ~pole_closed;
	// The normally open contacts sit in series, so one open pole breaks the chain.
	assign no_series  = &pole_closed;
endmodule : bfi_feeder_model
`default_nettype wire

// [tb/tb_bfi_top.sv]
/*
 * Self-checking bench for the breaker failure initiation block: bus tasks
 * and pin scenarios against the feeder and breaker model.
 * Assumes the design answers every bus request with a one-cycle ack.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_bfi_top;
	localparam int TC = 4;
	logic        sys_clk, resetn;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic        tpi, sni, rel, blk, negseq, cur_en, res_en, stuck;
	logic [2:0]  trip, pins, cur, nc, sps;
	logic        resid, nos, tps, retrip, backup;
	logic [15:0] odly;
	int          n_errors, cmp_count, n;

	bfi_top #(.TICK_CYCLES(TC)) i_bfi_top (.sys_clk(sys_clk), .resetn(resetn),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.phase_a_start_input(pins[0]), .phase_b_start_input(pins[1]),
		.phase_c_start_input(pins[2]), .three_pole_start_input(tpi),
		.start_no_current_input(sni), .release_input(rel), .block_input(blk),
		.phase_current_above(cur & {3{cur_en}}), .residual_current_above(resid & res_en),
		.negseq_current_above(negseq), .aux_nc_closed(nc), .aux_no_series_closed(nos),
		.single_phase_start(sps), .three_phase_start(tps), .retrip(retrip),
		.backup_trip(backup));

	bfi_feeder_model i_bfi_feeder_model (.sys_clk(sys_clk), .trip(trip), .stuck(stuck),
		.open_delay(odly), .start_pins(pins), .cur(cur), .resid(resid), .nc_closed(nc),
		.no_series(nos));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task give_verdict;
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	task chk_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (k >= 20)
			chk_bit("bus ack", 1'b1, wb_ack_o);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : wb_xfer

	task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		wb_xfer(1'b0, a, 32'h00000000);
		chk_word(what, exp, q);
	endtask : rd

	// Pins reach the start outputs three edges after a change; eight leaves margin.
	task drive(input logic [2:0] t);
		@(posedge sys_clk);
		trip <= t;
		repeat (8) @(posedge sys_clk);
	endtask : drive

	task wait_out(input logic bk, input int lim);
		n = 0;
		while ((bk ? backup : retrip) !== 1'b1 && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
	endtask : wait_out

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		give_verdict();
	end

	initial begin
		{resetn, wb_cyc_i, wb_stb_i, wb_we_i, tpi, sni, rel, blk, negseq} = 9'h000;
		{wb_adr_i, wb_sel_i, wb_dat_i, trip} = 47'h0;
		{cur_en, res_en, stuck} = 3'h7;
		odly = 16'h0002;
		n_errors = 0;
		cmp_count = 0;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd("ctrl reset", bfi_pkg::ADR_CTRL, 32'h00000011);
		rd("t1 single reset", bfi_pkg::ADR_T1_1P, 32'h00000064);
		rd("t1 three reset", bfi_pkg::ADR_T1_3P, 32'h00000064);
		rd("t2 reset", bfi_pkg::ADR_T2, 32'h000000c8);
		wb_xfer(1'b1, 8'h14, 32'h000000ff);
		rd("unmapped", 8'h14, 32'h00000000);
		wb_xfer(1'b1, bfi_pkg::ADR_T2, 32'h00000005);
		drive(3'b001);
		chk_bit("single start a", 1'b1, sps[0]);
		chk_bit("backup early", 1'b0, backup);
		wait_out(1'b1, 60);
		chk_bit("backup", 1'b1, backup);
		rd("status", bfi_pkg::ADR_STATUS, 32'h00000051);
		drive(3'b000);
		chk_bit("start dropped", 1'b0, sps[0]);
		chk_bit("backup dropped", 1'b0, backup);
		stuck <= 1'b0;
		drive(3'b001);
		repeat (60) @(posedge sys_clk);
		chk_bit("opened start", 1'b0, sps[0]);
		chk_bit("opened backup", 1'b0, backup);
		drive(3'b000);
		stuck <= 1'b1;
		blk <= 1'b1;
		drive(3'b001);
		chk_bit("ext block", 1'b0, sps[0]);
		blk <= 1'b0;
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000015);
		repeat (60) @(posedge sys_clk);
		chk_bit("int block", 1'b0, sps[0]);
		chk_bit("int block trip", 1'b0, backup);
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000013);
		drive(3'b001);
		chk_bit("release low", 1'b0, sps[0]);
		rel <= 1'b1;
		drive(3'b001);
		chk_bit("release high", 1'b1, sps[0]);
		rel <= 1'b0;
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000011);
		drive(3'b001);
		chk_bit("release unassigned", 1'b1, sps[0]);
		cur_en <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk_bit("current lockout", 1'b0, sps[0]);
		cur_en <= 1'b1;
		drive(3'b011);
		chk_bit("two pole three", 1'b1, tps);
		chk_word("two pole single", 32'h0, {29'h0, sps});
		drive(3'b000);
		sni <= 1'b1;
		drive(3'b000);
		chk_bit("no current three", 1'b1, tps);
		chk_word("no current single", 32'h0, {29'h0, sps});
		sni <= 1'b0;
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000019);
		repeat (8) @(posedge sys_clk);
		chk_bit("internal no current", 1'b1, tps);
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000011);
		cur_en <= 1'b0;
		drive(3'b001);
		chk_bit("contact fallback", 1'b1, sps[0]);
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000001);
		repeat (8) @(posedge sys_clk);
		chk_bit("series closed", 1'b1, sps[0]);
		stuck <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk_bit("series open", 1'b0, sps[0]);
		stuck <= 1'b1;
		drive(3'b000);
		drive(3'b001);
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000010);
		repeat (8) @(posedge sys_clk);
		chk_bit("contacts ignored", 1'b0, sps[0]);
		cur_en <= 1'b1;
		res_en <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk_bit("one threshold", 1'b0, sps[0]);
		negseq <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk_bit("two thresholds", 1'b1, sps[0]);
		{negseq, res_en} <= 2'b01;
		drive(3'b000);
		wb_xfer(1'b1, bfi_pkg::ADR_T1_1P, 32'h00000002);
		wb_xfer(1'b1, bfi_pkg::ADR_T2, 32'h00000008);
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000051);
		drive(3'b001);
		wait_out(1'b0, 60);
		chk_bit("retrip", 1'b1, retrip);
		chk_bit("backup after retrip", 1'b0, backup);
		wait_out(1'b1, 60);
		chk_bit("second stage", 1'b1, backup);
		drive(3'b000);
		wb_xfer(1'b1, bfi_pkg::ADR_T2, 32'h00000064);
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000031);
		drive(3'b001);
		wait_out(1'b1, 40);
		chk_bit("split backup", 1'b1, backup);
		chk_bit("split no retrip", 1'b0, retrip);
		drive(3'b000);
		wb_xfer(1'b1, bfi_pkg::ADR_CTRL, 32'h00000071);
		drive(3'b001);
		repeat (40) @(posedge sys_clk);
		chk_bit("no trip mode backup", 1'b0, backup);
		chk_bit("no trip mode retrip", 1'b0, retrip);
		drive(3'b000);
		give_verdict();
	end
endmodule : tb_bfi_top
`default_nettype wire
